// ### shared/tdv_pkg.sv
// shared constants and types of the two-digit interval voltmeter
package tdv_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int PERIOD_CLK_NS = 1200000;
  localparam int DECADE_CLK_NS = 3100000;
  localparam int OSC_FREQ_HZ = 20800;
  // derived cycle counts (rounded down, each well above one cycle)
  localparam int PERIOD_CLK_CYC = PERIOD_CLK_NS / CLK_PERIOD_NS;
  localparam int DECADE_CLK_CYC = DECADE_CLK_NS / CLK_PERIOD_NS;
  localparam int OSC_CYC = CLK_FREQ_HZ / OSC_FREQ_HZ;
  // converter and decade code layout
  localparam int ADC_W = 8;
  localparam int CODE_W = 4;
  localparam int SEG_W = 7;
  localparam logic [3:0] CODE_FIRST = 4'hF;
  localparam logic [3:0] CODE_LAST = 4'h6;
  localparam logic [6:0] SEG_RESET_N = 7'h7F;
  localparam logic [7:0] OFFSET_DELAY_DEF = 8'h0D;
  // shortest reload in period ticks; a one-tick period would hold the output high
  localparam logic [7:0] PERIOD_MIN = 8'h02;
  // sequencing states
  typedef enum logic [1:0] {ST_START, ST_OFFSET, ST_RUN} tdv_state_e;
endpackage : tdv_pkg

// ### design/tdv_seg_decoder.sv
// seven-segment decoder for the down-counting decade code
`timescale 1ns/100ps
`default_nettype none
module tdv_seg_decoder
  import tdv_pkg::*;
(
  // decade code in
  input wire logic [CODE_W-1:0] code,
  // segments g..a, active low
  output logic [SEG_W-1:0] seg_n
);
  logic [SEG_W-1:0] seg_on;

  // code 1111 shows 0, each step down shows the next digit, 0110 shows 9
  always_comb begin
    case (code)
      4'hF: seg_on = 7'h3F;
      4'hE: seg_on = 7'h06;
      4'hD: seg_on = 7'h5B;
      4'hC: seg_on = 7'h4F;
      4'hB: seg_on = 7'h66;
      4'hA: seg_on = 7'h6D;
      4'h9: seg_on = 7'h7D;
      4'h8: seg_on = 7'h07;
      4'h7: seg_on = 7'h7F;
      4'h6: seg_on = 7'h6F;
      default: seg_on = 7'h00; // illegal codes stay dark
    endcase
  end

  // segments sink current, so a lit segment is a low pin
  assign seg_n = ~seg_on;
endmodule : tdv_seg_decoder
`default_nettype wire

// ### design/tdv_voltmeter.sv
// digital core of the two-digit interval voltmeter
// Function
// - each segment a..g has own decoded output
// - period counter reloads converter value, one-tick pulse
// - decade counters step ten codes 1111 to 0110
// - first counter units, second counter tens
// - units wrap gives one tens clock pulse
// - latch on period rise, then clear counters
// - period clock 1.2ms, decade clock 3.1ms
// - offset of converter compensated digitally
// - start-up: period high, latches zero, counters cleared
// - after offset delay period counter released
// - offset delay count is adjustable
// - decade overflow forces return to start-up state
// - oscillator divided by two gives display phase
// - phase selects units or tens latch
// - two digit selects, one per phase
`timescale 1ns/100ps
`default_nettype none
module tdv_voltmeter
  import tdv_pkg::*;
#(
  parameter int PERIOD_CYC = PERIOD_CLK_CYC,
  parameter int DECADE_CYC = DECADE_CLK_CYC,
  parameter int OSC_HALF_CYC = OSC_CYC
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter value and offset trim pins
  input wire logic [ADC_W-1:0] adc_value,
  input wire logic [7:0] offset_delay,
  // display pins
  output logic [SEG_W-1:0] seg_n,
  output logic units_digit_select,
  output logic tens_digit_select,
  // period counter output
  output logic period_out
);
  // tick dividers: 0 period clock, 1 decade clock, 2 display oscillator
  localparam int NDIV = 3;
  localparam int DIV_LIM [NDIV] = '{PERIOD_CYC, DECADE_CYC, OSC_HALF_CYC};

  logic [NDIV-1:0] tick;
  logic [ADC_W-1:0] adc_s1_reg, adc_s2_reg;
  logic [7:0] off_s1_reg, off_s2_reg;
  tdv_state_e state_reg, state_next;
  logic [ADC_W-1:0] pcnt_reg, pcnt_next;
  logic [7:0] ocnt_reg, ocnt_next;
  logic pout_reg, pout_next, pout_d_reg;
  logic latch_pulse, clr_pulse_reg;
  logic [3:0] units_reg, units_next, tens_reg, tens_next;
  logic [3:0] units_latch_reg, units_latch_next, tens_latch_reg, tens_latch_next;
  logic overflow, units_wrap;
  logic phase_reg, phase_next;
  logic [3:0] shown_code;
  logic [SEG_W-1:0] seg_dec, seg_reg;
  logic usel_reg, tsel_reg;

  // one step of the down-counting decade code, wrapping after 0110
  function automatic logic [3:0] dec_step(input logic [3:0] c);
    dec_step = (c == CODE_LAST) ? CODE_FIRST : c - 4'h1;
  endfunction : dec_step

  // reload value; below two ticks the output never falls, so no edge would latch
  function automatic logic [7:0] reload_of(input logic [7:0] v);
    reload_of = (v < PERIOD_MIN) ? PERIOD_MIN : v;
  endfunction : reload_of

  // free-running prescalers; clock times set the full-scale match of 255 and 99
  for (genvar i = 0; i < NDIV; i++) begin : g_div
    logic [31:0] cnt_reg, cnt_next;
    always_comb begin
      cnt_next = (cnt_reg >= 32'(DIV_LIM[i] - 1)) ? 32'h0 : cnt_reg + 32'h1;
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_reg <= 32'h0;
      end else begin
        cnt_reg <= cnt_next;
      end
    end
    assign tick[i] = (cnt_reg == 32'(DIV_LIM[i] - 1));
  end

  // pins from outside pass two flops; the value is slow so bit skew settles
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_s1_reg <= 8'h00;
      adc_s2_reg <= 8'h00;
      off_s1_reg <= OFFSET_DELAY_DEF;
      off_s2_reg <= OFFSET_DELAY_DEF;
    end else begin
      adc_s1_reg <= adc_value;
      adc_s2_reg <= adc_s1_reg;
      off_s1_reg <= offset_delay;
      off_s2_reg <= off_s1_reg;
    end
  end

  // period counter, offset delay and sequencing
  always_comb begin
    state_next = state_reg;
    pcnt_next = pcnt_reg;
    ocnt_next = ocnt_reg;
    pout_next = pout_reg;
    case (state_reg)
      ST_START: begin
        pout_next = 1'b1;
        ocnt_next = 8'h00;
        state_next = ST_OFFSET;
      end
      ST_OFFSET: begin
        // period counter held while the high output runs through the delay
        if (tick[0]) begin
          if (ocnt_reg + 8'h1 >= off_s2_reg) begin
            pcnt_next = reload_of(adc_s2_reg);
            pout_next = 1'b0;
            state_next = ST_RUN;
          end else begin
            ocnt_next = ocnt_reg + 8'h1;
          end
        end
      end
      default: begin
        // values 0 and 1 run as two ticks, the shortest period that still pulses
        if (tick[0]) begin
          if (pcnt_reg <= 8'h01) begin
            pcnt_next = reload_of(adc_s2_reg);
            pout_next = 1'b1;
          end else begin
            pcnt_next = pcnt_reg - 8'h1;
            pout_next = 1'b0;
          end
        end
      end
    endcase
    if (overflow) begin
      state_next = ST_START;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_START;
      pcnt_reg <= 8'h01;
      ocnt_reg <= 8'h00;
      pout_reg <= 1'b1;
      pout_d_reg <= 1'b1;
      clr_pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pcnt_reg <= pcnt_next;
      ocnt_reg <= ocnt_next;
      pout_reg <= pout_next;
      pout_d_reg <= pout_reg;
      clr_pulse_reg <= latch_pulse;
    end
  end

  // latch first on the rising edge, clear one cycle later
  assign latch_pulse = pout_reg & ~pout_d_reg;
  assign units_wrap = tick[1] & (units_reg == CODE_LAST);
  assign overflow = units_wrap & (tens_reg == CODE_LAST);

  // decade counters and display latches
  always_comb begin
    units_next = units_reg;
    tens_next = tens_reg;
    units_latch_next = units_latch_reg;
    tens_latch_next = tens_latch_reg;
    if (state_reg == ST_START || clr_pulse_reg) begin
      units_next = CODE_FIRST;
      tens_next = CODE_FIRST;
    end else if (tick[1]) begin
      units_next = dec_step(units_reg);
      if (units_wrap) begin
        tens_next = dec_step(tens_reg);
      end
    end
    if (state_reg == ST_START) begin
      units_latch_next = CODE_FIRST;
      tens_latch_next = CODE_FIRST;
    end else if (latch_pulse) begin
      units_latch_next = units_reg;
      tens_latch_next = tens_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      units_reg <= CODE_FIRST;
      tens_reg <= CODE_FIRST;
      units_latch_reg <= CODE_FIRST;
      tens_latch_reg <= CODE_FIRST;
    end else begin
      units_reg <= units_next;
      tens_reg <= tens_next;
      units_latch_reg <= units_latch_next;
      tens_latch_reg <= tens_latch_next;
    end
  end

  // display phase: oscillator divided by two gives equal time per digit
  assign phase_next = tick[2] ? ~phase_reg : phase_reg;
  assign shown_code = phase_reg ? tens_latch_reg : units_latch_reg;

  tdv_seg_decoder u_dec (
    .code(shown_code),
    .seg_n(seg_dec)
  );

  // outputs registered together so segments never lead their select
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= 1'b0;
      seg_reg <= SEG_RESET_N;
      usel_reg <= 1'b0;
      tsel_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      seg_reg <= seg_dec;
      usel_reg <= ~phase_reg;
      tsel_reg <= phase_reg;
    end
  end

  assign seg_n = seg_reg;
  assign units_digit_select = usel_reg;
  assign tens_digit_select = tsel_reg;
  assign period_out = pout_reg;

  // helper: cycles the period output has stayed high while running
  logic [31:0] hi_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst || !pout_reg || state_reg != ST_RUN) begin
      hi_cnt_reg <= 32'h0;
    end else begin
      hi_cnt_reg <= hi_cnt_reg + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  seg_zero_a: assert property (
    (!$past(phase_reg) && $past(units_latch_reg) == CODE_FIRST && !rst && !$past(rst))
      |-> seg_n == 7'h40)
    else $error("units zero not decoded");
  pulse_width_a: assert property (hi_cnt_reg <= 32'(PERIOD_CYC))
    else $error("period pulse wider than one tick");
  code_range_a: assert property (units_reg >= CODE_LAST && tens_reg >= CODE_LAST)
    else $error("decade code out of range");
  tens_carry_a: assert property (
    (units_wrap && tens_reg != CODE_LAST && state_reg != ST_START && !clr_pulse_reg)
      |=> tens_reg == $past(tens_reg) - 4'h1)
    else $error("tens did not advance on units wrap");
  latch_then_clear_a: assert property (
    latch_pulse && state_reg != ST_START
      |=> units_latch_reg == $past(units_reg) && clr_pulse_reg ##1 units_reg == CODE_FIRST)
    else $error("latch and clear order broken");
  startup_state_a: assert property (
    state_reg == ST_START |=> pout_reg && units_latch_reg == CODE_FIRST
      && tens_latch_reg == CODE_FIRST)
    else $error("start-up values wrong");
  offset_hold_a: assert property (state_reg == ST_OFFSET && !tick[0] |=> pout_reg)
    else $error("period output dropped during offset delay");
  overflow_reset_a: assert property (overflow |=> state_reg == ST_START)
    else $error("overflow did not reset system");
  phase_toggle_a: assert property (tick[2] |=> phase_reg != $past(phase_reg))
    else $error("display phase did not toggle");
  digit_select_a: assert property (
    !$past(rst) |-> units_digit_select != tens_digit_select
      && tens_digit_select == $past(phase_reg))
    else $error("digit selects not one per phase");

  run_reached_c: cover property (state_reg == ST_OFFSET ##1 state_reg == ST_RUN);
  overflow_c: cover property (overflow);
  tens_latched_c: cover property (latch_pulse ##1 tens_latch_reg != CODE_FIRST);
endmodule : tdv_voltmeter
`default_nettype wire

// ### tb/tdv_display_model.sv
// display partner: reads back the digit that each common anode would light
`timescale 1ns/100ps
`default_nettype none
module tdv_display_model
  import tdv_pkg::*;
(
  // pins from the meter
  input wire logic clk,
  input wire logic [SEG_W-1:0] seg_n,
  input wire logic units_digit_select,
  input wire logic tens_digit_select,
  // digits a viewer reads, F when the pattern is no digit
  output logic [3:0] units_shown,
  output logic [3:0] tens_shown
);
  // segments sink current, bit0 is a; an unknown pattern never reads as a digit
  function automatic logic [3:0] seen(input logic [SEG_W-1:0] s);
    case (s)
      7'h40: seen = 4'h0;
      7'h79: seen = 4'h1;
      7'h24: seen = 4'h2;
      7'h30: seen = 4'h3;
      7'h19: seen = 4'h4;
      7'h12: seen = 4'h5;
      7'h02: seen = 4'h6;
      7'h78: seen = 4'h7;
      7'h00: seen = 4'h8;
      7'h10: seen = 4'h9;
      default: seen = 4'hF;
    endcase
  endfunction : seen
  // a digit lights only while its anode is driven high
  always @(posedge clk) begin
    if (units_digit_select === 1'b1) units_shown <= seen(seg_n);
    if (tens_digit_select === 1'b1) tens_shown <= seen(seg_n);
  end
endmodule : tdv_display_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the two-digit interval voltmeter
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tdv_pkg::*;
  localparam int PC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic live = 1'b0;
  logic last_sel = 1'b0;
  logic [ADC_W-1:0] adc_value = 8'h01;
  logic [7:0] offset_delay = 8'h03;
  logic [SEG_W-1:0] seg_n;
  logic units_digit_select;
  logic tens_digit_select;
  logic period_out;
  logic [3:0] units_shown;
  logic [3:0] tens_shown;
  int bad_count = 0;
  int compares = 0;
  int seed = 47860;
  int run = 0;
  int seen_chg = 0;
  int corner[3] = '{0, 1, 40};
  always #5 clk = ~clk;
  tdv_voltmeter #(.PERIOD_CYC(PC), .DECADE_CYC(9), .OSC_HALF_CYC(4)) u_tdv_voltmeter (
    .clk(clk), .rst(rst), .adc_value(adc_value), .offset_delay(offset_delay),
    .seg_n(seg_n), .units_digit_select(units_digit_select),
    .tens_digit_select(tens_digit_select), .period_out(period_out));
  tdv_display_model u_tdv_display_model (
    .clk(clk), .seg_n(seg_n), .units_digit_select(units_digit_select),
    .tens_digit_select(tens_digit_select), .units_shown(units_shown),
    .tens_shown(tens_shown));
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  // readings carry a tick of jitter from the free-running decade clock
  task automatic cmp_near(input logic [31:0] got, input logic [31:0] exp, input int tol);
    compares++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_near
  function automatic logic [31:0] reading();
    return tens_shown * 10 + units_shown;
  endfunction : reading
  // period in ticks: short values are stretched to the shortest pulsing period
  function automatic int exp_ticks(input int v);
    return (v < int'(PERIOD_MIN)) ? int'(PERIOD_MIN) : v;
  endfunction : exp_ticks
  function automatic int exp_count(input int v);
    return exp_ticks(v) * PC / 9;
  endfunction : exp_count
  // bounded wait for the period output to reach a level
  task automatic wait_level(input logic lvl, input int lim, output int n);
    n = 0;
    while (period_out !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (period_out !== lvl) begin
      bad_count++;
      conclude();
    end
  endtask : wait_level
  task automatic do_reset(input int d);
    int hi;
    @(posedge clk) begin
      rst <= 1'b1;
      offset_delay <= d[7:0];
    end
    repeat (5) @(posedge clk);
    @(negedge clk);
    cmp_val(seg_n, SEG_RESET_N);
    cmp_val({units_digit_select, tens_digit_select, period_out}, 3'b001);
    @(posedge clk) rst <= 1'b0;
    repeat (12) @(negedge clk);
    cmp_val(reading(), 0);
    wait_level(1'b0, 2000, hi);
    cmp_near(hi + 13, d * PC, 2 * PC);
  endtask : do_reset
  task automatic check_adc(input int v);
    int hi;
    int lo;
    @(posedge clk) adc_value <= v[7:0];
    repeat (3) begin
      wait_level(1'b0, 2000, hi);
      wait_level(1'b1, 2000, lo);
    end
    wait_level(1'b0, 100, hi);
    wait_level(1'b1, 2000, lo);
    cmp_val(hi, PC);
    cmp_val(hi + lo, exp_ticks(v) * PC);
    repeat (12) @(negedge clk);
    cmp_near(reading(), exp_count(v), 2);
  endtask : check_adc
  // the latch delays the design's view of reset by one edge
  always @(posedge clk) live <= !rst;
  // each select stands a full display phase and the two never light together
  always @(negedge clk) begin
    if (live !== 1'b1) begin
      seen_chg = 0;
      run = 0;
    end else begin
      cmp_val(tens_digit_select, !units_digit_select);
      if (units_digit_select !== last_sel) begin
        if (seen_chg != 0) cmp_val(run, 4);
        seen_chg = 1;
        run = 1;
      end else begin
        run++;
      end
    end
    last_sel = units_digit_select;
  end
  // corners, random values, a mid-run reset, then a reading past 99
  initial begin
    do_reset(3);
    foreach (corner[i]) check_adc(corner[i]);
    repeat (4) check_adc(1 + ($unsigned($random(seed)) % 40));
    do_reset(2 + ($unsigned($random(seed)) % 10));
    check_adc(1 + ($unsigned($random(seed)) % 40));
    @(posedge clk) begin
      offset_delay <= 8'h01;
      adc_value <= 8'h3C;
    end
    repeat (3000) @(negedge clk);
    cmp_near(reading(), 0, 5);
    conclude();
  end
endmodule : tb
`default_nettype wire
